/* hdl/pis_regs.svh */
// constants for the product id response sequencer
`ifndef PIS_REGS_SVH
`define PIS_REGS_SVH
`define PIS_SYNC1_A      8'h86
`define PIS_SYNC1_B      8'h30
`define PIS_SYNC2_A      8'h79
`define PIS_SYNC2_B      8'hCF
`define PIS_CMD_ID       8'hC0
`define PIS_ERR_SYNC     8'hA1
`define PIS_ERR_CMD      8'h63
`define PIS_ERR_REPEAT   2'h3
`define PIS_REPLY_LEN    5'h16
`define PIS_PAYLOAD_LO   5'h02
`define PIS_PAYLOAD_HI   5'h14
`define PIS_SIZE_LSB     3
`define PIS_BAUD_MIN     16'h0004
`endif

/* hdl/pis_pkg.sv */
// types for the product id response sequencer
package pis_pkg;
    typedef enum logic [2:0] {
        PIS_WAIT_SYNC1 = 3'b000,
        PIS_WAIT_SYNC2 = 3'b001,
        PIS_WAIT_CMD   = 3'b010,
        PIS_ECHO       = 3'b011,
        PIS_REPLY      = 3'b100,
        PIS_ERROR      = 3'b101,
        PIS_IDLE       = 3'b110
    } pis_state_t;
endpackage

/* hdl/pis_reply_rom.sv */
// fixed reply table, registered read data
`timescale 1ns/100ps
module pis_reply_rom
(
    input  wire logic       clk,
    input  wire logic [4:0] addr,
    output logic      [7:0] data
);
    logic [7:0] table_byte;

    always_comb
    begin
        unique case (addr)
            5'h00:   table_byte = 8'h3A;
            5'h01:   table_byte = 8'h13;
            5'h02:   table_byte = 8'h03;
            5'h03:   table_byte = 8'hFD;
            5'h07:   table_byte = 8'h40;
            5'h08:   table_byte = 8'h01;
            5'h0A:   table_byte = 8'hC0;
            5'h0D:   table_byte = 8'hFF;
            5'h0E:   table_byte = 8'hFF;
            5'h11:   table_byte = 8'h60;
            5'h13:   table_byte = 8'h08;
            5'h14:   table_byte = 8'h3F;
            default: table_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        data <= table_byte;
    end
endmodule

/* hdl/pis_sequencer.sv */
// product id command handler with autobaud serial link
//
// Contract
// - the bit period is measured on the first byte and used for all later bytes both ways.
// - a valid first sync byte is echoed, an invalid one gets no answer.
// - a second sync byte of 0x79 or 0xCF is echoed, otherwise nothing is sent.
// - command 0xC0 is echoed when accepted.
// - a rejected command gives one error code three times, then idle.
// - after the echo come start mark 0x3A and count 0x13.
// - the first payload byte is 0x03 then reserved 0xFD 0x00 0x00 0x00.
// - the ninth byte sent, counting the echo, is the flash size code 0x40.
// - the size code holds the size field in bits 7..3 and zeros below.
// - block count 0x01 then flash range 00 C0 00 to 00 FF FF.
// - loader memory range 00 00 60 to 00 08 3F follows.
// - the last byte is the two's complement of the sum of payload bytes.
// - after the checksum the device waits for the next command at the same rate.
`timescale 1ns/100ps
`include "pis_regs.svh"
module pis_sequencer
    import pis_pkg::*;
#(
    parameter int BAUD_W = 16
)
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic rxd,
    output logic      txd,
    output logic      busy,
    output logic      idle
);
    if (BAUD_W < 8 || BAUD_W > 24)
    begin
        $error("BAUD_W out of range");
    end

    typedef enum logic [1:0] {
        PIS_RX_IDLE  = 2'b00,
        PIS_RX_START = 2'b01,
        PIS_RX_DATA  = 2'b10,
        PIS_RX_STOP  = 2'b11
    } pis_rx_t;

    typedef struct packed {
        logic [2:0]        sync;
        logic              rx_line;
        pis_state_t        state;
        logic              baud_ok;
        logic [BAUD_W-1:0] bit_len;
        logic [BAUD_W-1:0] meas;
        logic              measuring;
        pis_rx_t           rx;
        logic [BAUD_W-1:0] rx_cnt;
        logic [3:0]        rx_bit;
        logic [7:0]        rx_sh;
        logic              tx_on;
        logic [BAUD_W-1:0] tx_cnt;
        logic [3:0]        tx_bit;
        logic [9:0]        tx_sh;
        logic [7:0]        echo;
        logic [4:0]        idx;
        logic              rom_ok;
        logic [1:0]        err_n;
        logic [7:0]        err_code;
        logic [7:0]        sum;
        logic              txd;
        logic              busy;
        logic              idle;
    } pis_regs_t;

    pis_regs_t  r;
    pis_regs_t  next_r;
    logic [7:0] rom_data;
    logic       rx_done;
    logic [7:0] rx_byte;

    pis_reply_rom u_rom
    (
        .clk  (core_clk),
        .addr (next_r.idx),
        .data (rom_data)
    );

    always_comb
    begin
        next_r = r;
        rx_done = 1'b0;
        rx_byte = r.rx_sh;
        // -----------------------------------------------------------
        // pin synchroniser, change taken once stages two and three agree
        // -----------------------------------------------------------
        next_r.sync = {r.sync[1:0], rxd};
        if (r.sync[2] == r.sync[1])
            next_r.rx_line = r.sync[2];
        // -----------------------------------------------------------
        // autobaud: width of the first low run on the line, start bit plus any low bits after it
        // -----------------------------------------------------------
        if (!r.baud_ok)
        begin
            if (!r.measuring && r.rx_line && !next_r.rx_line)
            begin
                next_r.measuring = 1'b1;
                next_r.meas = '0;
            end
            else if (r.measuring && !r.rx_line)
                next_r.meas = r.meas + 1'b1;
            else if (r.measuring && r.rx_line)
            begin
                // low run is taken as one bit time; counters reload one less
                // so that a bit spans exactly meas cycles both ways
                next_r.measuring = 1'b0;
                next_r.baud_ok = (r.meas >= `PIS_BAUD_MIN);
                next_r.bit_len = r.meas - 1'b1;
            end
        end
        // -----------------------------------------------------------
        // receiver
        // -----------------------------------------------------------
        unique case (r.rx)
            PIS_RX_IDLE:
                if (r.baud_ok && r.rx_line && !next_r.rx_line)
                begin
                    next_r.rx = PIS_RX_START;
                    next_r.rx_cnt = r.bit_len >> 1;
                end
            PIS_RX_START, PIS_RX_DATA, PIS_RX_STOP:
                if (r.rx_cnt != '0)
                    next_r.rx_cnt = r.rx_cnt - 1'b1;
                else
                begin
                    next_r.rx_cnt = r.bit_len;
                    if (r.rx == PIS_RX_START)
                    begin
                        next_r.rx = r.rx_line ? PIS_RX_IDLE : PIS_RX_DATA;
                        next_r.rx_bit = 4'h0;
                    end
                    else if (r.rx == PIS_RX_DATA)
                    begin
                        next_r.rx_sh = {r.rx_line, r.rx_sh[7:1]};
                        next_r.rx_bit = r.rx_bit + 4'h1;
                        if (r.rx_bit == 4'h7)
                            next_r.rx = PIS_RX_STOP;
                    end
                    else
                    begin
                        next_r.rx = PIS_RX_IDLE;
                        rx_done = r.rx_line;
                    end
                end
        endcase
        // -----------------------------------------------------------
        // transmitter, same bit length as receiver
        // -----------------------------------------------------------
        if (r.tx_on)
        begin
            if (r.tx_cnt != '0)
                next_r.tx_cnt = r.tx_cnt - 1'b1;
            else
            begin
                next_r.tx_cnt = r.bit_len;
                next_r.tx_sh = {1'b1, r.tx_sh[9:1]};
                next_r.tx_bit = r.tx_bit + 4'h1;
                if (r.tx_bit == 4'h9)
                    next_r.tx_on = 1'b0;
            end
        end
        // -----------------------------------------------------------
        // command sequencer
        // -----------------------------------------------------------
        unique case (r.state)
            PIS_WAIT_SYNC1:
                if (rx_done)
                begin
                    if (rx_byte == `PIS_SYNC1_A || rx_byte == `PIS_SYNC1_B)
                    begin
                        next_r.echo = rx_byte;
                        next_r.state = PIS_ECHO;
                        next_r.idx = 5'h1F;
                    end
                end
            PIS_WAIT_SYNC2:
                if (rx_done)
                begin
                    if (rx_byte == `PIS_SYNC2_A || rx_byte == `PIS_SYNC2_B)
                    begin
                        next_r.echo = rx_byte;
                        next_r.state = PIS_ECHO;
                        next_r.idx = 5'h1E;
                    end
                end
            PIS_WAIT_CMD:
                if (rx_done)
                begin
                    if (rx_byte == `PIS_CMD_ID)
                    begin
                        next_r.echo = rx_byte;
                        next_r.state = PIS_ECHO;
                        next_r.idx = 5'h00;
                    end
                    else
                    begin
                        next_r.err_code = `PIS_ERR_CMD;
                        next_r.err_n = 2'h0;
                        next_r.state = PIS_ERROR;
                    end
                end
            PIS_ECHO:
                if (!r.tx_on)
                begin
                    next_r.tx_on = 1'b1;
                    next_r.tx_cnt = r.bit_len;
                    next_r.tx_bit = 4'h0;
                    next_r.tx_sh = {1'b1, r.echo, 1'b0};
                    next_r.rom_ok = 1'b0;
                    next_r.sum = 8'h00;
                    if (r.idx == 5'h1F)
                        next_r.state = PIS_WAIT_SYNC2;
                    else if (r.idx == 5'h1E)
                        next_r.state = PIS_WAIT_CMD;
                    else
                        next_r.state = PIS_REPLY;
                end
            PIS_REPLY:
                if (!r.rom_ok)
                    next_r.rom_ok = 1'b1;
                else if (!r.tx_on)
                begin
                    next_r.tx_on = 1'b1;
                    next_r.tx_cnt = r.bit_len;
                    next_r.tx_bit = 4'h0;
                    next_r.rom_ok = 1'b0;
                    if (r.idx == `PIS_REPLY_LEN - 5'h1)
                    begin
                        next_r.tx_sh = {1'b1, 8'h00 - r.sum, 1'b0};
                        next_r.state = PIS_WAIT_CMD;
                    end
                    else
                    begin
                        // table bytes
                        next_r.tx_sh = {1'b1, rom_data, 1'b0};
                        if (r.idx >= `PIS_PAYLOAD_LO && r.idx <= `PIS_PAYLOAD_HI)
                            next_r.sum = r.sum + rom_data;
                        next_r.idx = r.idx + 5'h1;
                    end
                end
            PIS_ERROR:
                if (!r.tx_on)
                begin
                    if (r.err_n == `PIS_ERR_REPEAT)
                        next_r.state = PIS_IDLE;
                    else
                    begin
                        next_r.tx_on = 1'b1;
                        next_r.tx_cnt = r.bit_len;
                        next_r.tx_bit = 4'h0;
                        next_r.tx_sh = {1'b1, r.err_code, 1'b0};
                        next_r.err_n = r.err_n + 2'h1;
                    end
                end
            PIS_IDLE:
                next_r.state = PIS_IDLE;
            default:
                next_r.state = PIS_IDLE;
        endcase
        next_r.txd = next_r.tx_on ? next_r.tx_sh[0] : 1'b1;
        next_r.busy = next_r.tx_on || (next_r.state inside {PIS_ECHO, PIS_REPLY, PIS_ERROR});
        next_r.idle = (next_r.state == PIS_IDLE);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            r <= '0;
            r.sync <= 3'h7;
            r.rx_line <= 1'b1;
            r.txd <= 1'b1;
            r.state <= PIS_WAIT_SYNC1;
            r.rx <= PIS_RX_IDLE;
        end
        else
            r <= next_r;
    end

    assign txd = r.txd;
    assign busy = r.busy;
    assign idle = r.idle;

    a_err_idle_stays: assert property (@(posedge core_clk) disable iff (rst)
        r.state == PIS_IDLE |=> r.state == PIS_IDLE && txd)
        else $error("idle state left or line driven");
    a_tx_uses_baud: assert property (@(posedge core_clk) disable iff (rst)
        r.tx_on && r.tx_cnt == '0 && r.tx_bit != 4'h9 |=> r.tx_cnt == r.bit_len)
        else $error("transmit bit length differs from measured");
    a_err_count_three: assert property (@(posedge core_clk) disable iff (rst)
        r.state == PIS_ERROR && !r.tx_on && r.err_n == `PIS_ERR_REPEAT |=> r.state == PIS_IDLE && !r.tx_on)
        else $error("error code sent too often");
    a_sum_cleared: assert property (@(posedge core_clk) disable iff (rst)
        r.state == PIS_ECHO && !r.tx_on |=> r.sum == 8'h00)
        else $error("checksum not cleared");
    a_check_done: assert property (@(posedge core_clk) disable iff (rst)
        $past(r.state) == PIS_REPLY && $past(r.idx) == 5'h15 &&
        r.tx_on && !$past(r.tx_on) |-> r.tx_sh[8:1] == 8'h00 - $past(r.sum))
        else $error("checksum byte wrong");
    a_reply_back_cmd: assert property (@(posedge core_clk) disable iff (rst)
        $past(r.state) == PIS_REPLY && r.state == PIS_WAIT_CMD |-> r.tx_on)
        else $error("return to command wait without checksum");
    a_bad_sync_silent: assert property (@(posedge core_clk) disable iff (rst)
        r.state == PIS_WAIT_SYNC1 && !r.tx_on |=> !r.tx_on)
        else $error("transmit while waiting for first sync");
    a_cmd_echo: assert property (@(posedge core_clk) disable iff (rst)
        r.state == PIS_WAIT_CMD && rx_done && rx_byte == `PIS_CMD_ID |=> r.echo == `PIS_CMD_ID
        ##1 r.tx_sh[8:1] == `PIS_CMD_ID)
        else $error("command not echoed");
    c_reply: cover property (@(posedge core_clk) r.state == PIS_REPLY ##1 r.state == PIS_WAIT_CMD);
    c_error: cover property (@(posedge core_clk) r.state == PIS_ERROR ##1 r.state == PIS_IDLE);
    c_sync2: cover property (@(posedge core_clk) r.state == PIS_WAIT_SYNC2);
endmodule

/* verification/pis_ctl_model.sv */
// serial programming controller model: sends 8N1 frames, decodes the device's replies
`timescale 1ns/100ps
module pis_ctl_model
(
    input  wire logic       core_clk,
    input  wire logic       txd,
    output logic            rxd,
    output logic            rx_valid,
    output logic      [7:0] rx_data
);
    int         bit_len = 40;
    logic [7:0] sh;

    initial
    begin
        rxd      = 1'b1;
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end

    // ----------------------------------------------------------------
    // transmit side
    // ----------------------------------------------------------------
    // lsb first; line is left high, the idle level of the link
    task automatic send_byte(input logic [7:0] b, input int len);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            #1 rxd = fr[i];
            repeat (len - 1) @(posedge core_clk);
        end
    endtask

    // ----------------------------------------------------------------
    // receive side
    // ----------------------------------------------------------------
    // device bits span the trained length; sampling lands mid-bit
    always
    begin
        @(negedge txd);
        repeat (bit_len / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_len) @(posedge core_clk);
            sh[i] = txd;
        end
        repeat (bit_len) @(posedge core_clk);
        #1 rx_data = sh;
        rx_valid = 1'b1;
        @(posedge core_clk);
        #1 rx_valid = 1'b0;
    end
endmodule

/* verification/tb_top.sv */
// self-checking bench for the product id response sequencer
`timescale 1ns/100ps
`include "pis_regs.svh"
module tb_top;
    localparam int DLY = 1;
    localparam logic [7:0] REPLY [21] = '{8'h3A, 8'h13, 8'h03, 8'hFD, 8'h00, 8'h00, 8'h00,
        8'h40, 8'h01, 8'h00, 8'hC0, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h60, 8'h00,
        8'h08, 8'h3F};
    logic       core_clk;
    logic       rst;
    logic       rxd;
    logic       txd;
    logic       busy;
    logic       idle;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic [7:0] exp_q[$];
    int         n_mismatch = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         len = 40;

    pis_sequencer #(.BAUD_W(16)) pis_sequencer_inst (.core_clk(core_clk), .rst(rst), .rxd(rxd),
        .txd(txd), .busy(busy), .idle(idle));
    pis_ctl_model pis_ctl_model_inst (.core_clk(core_clk), .txd(txd), .rxd(rxd),
        .rx_valid(rx_valid), .rx_data(rx_data));

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // a byte with no note pending compares against unknown and so always fails
    always @(posedge core_clk)
        if (rx_valid === 1'b1)
            check(rx_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles >= 90000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    task automatic settle();
        int n;
        n = 0;
        repeat (4) @(posedge core_clk);
        while (busy !== 1'b0 && n < 20000)
        begin
            @(posedge core_clk);
            n++;
        end
        repeat (3 * len) @(posedge core_clk);
    endtask

    task automatic send(input logic [7:0] b, input bit echo);
        if (echo)
            exp_q.push_back(b);
        pis_ctl_model_inst.send_byte(b, len);
        settle();
    endtask

    task automatic rand_not(input logic [7:0] a, input logic [7:0] b, output logic [7:0] r);
        do
            r = 8'($urandom);
        while (r == a || r == b);
    endtask

    // training frame at twice the rate: start plus bit 0 of 0x86 give one bit time low
    task automatic open_link(input int l, input logic [7:0] s1, input logic [7:0] s2);
        logic [7:0] bad;
        len = l;
        pis_ctl_model_inst.bit_len = l;
        pis_ctl_model_inst.send_byte(`PIS_SYNC1_A, l / 2);
        settle();
        // receiver still runs over the tail of the training frame
        repeat (5 * l) @(posedge core_clk);
        rand_not(`PIS_SYNC1_A, `PIS_SYNC1_B, bad);
        send(bad, 1'b0);
        send(s1, 1'b1);
        rand_not(`PIS_SYNC2_A, `PIS_SYNC2_B, bad);
        send(bad, 1'b0);
        send(s2, 1'b1);
    endtask

    task automatic run_id();
        logic [7:0] cs;
        cs = 8'h00;
        exp_q.push_back(`PIS_CMD_ID);
        for (int i = 0; i < 21; i++)
            exp_q.push_back(REPLY[i]);
        for (int i = 2; i < 21; i++)
            cs = cs + REPLY[i];
        exp_q.push_back(8'h00 - cs);
        send(`PIS_CMD_ID, 1'b0);
    endtask

    initial
    begin
        logic [7:0] bad;
        void'($urandom(92));
        rst = 1'b1;
        repeat (12) @(posedge core_clk);
        #DLY rst = 1'b0;
        repeat (2) @(posedge core_clk);
        check({5'h00, txd, busy, idle}, 8'h04);
        open_link(40, `PIS_SYNC1_A, `PIS_SYNC2_A);
        run_id();
        run_id();
        rand_not(`PIS_CMD_ID, `PIS_CMD_ID, bad);
        repeat (3) exp_q.push_back(`PIS_ERR_CMD);
        send(bad, 1'b0);
        check({7'h00, idle}, 8'h01);
        send(`PIS_CMD_ID, 1'b0);
        check({7'h00, idle}, 8'h01);
        @(posedge core_clk);
        #DLY rst = 1'b1;
        repeat (12) @(posedge core_clk);
        #DLY rst = 1'b0;
        repeat (2) @(posedge core_clk);
        check({6'h00, busy, idle}, 8'h00);
        // a fresh rate after reset must be learned again
        open_link(28, `PIS_SYNC1_B, `PIS_SYNC2_B);
        run_id();
        check(8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule
